// ==== iec_defines.svh ====
// Purpose: Constants for the incremental encoder counter
// Assumes: 32-bit Avalon-MM register bus, word addressed by byte offset
// Notes:   Offsets are byte addresses; each channel owns a block
`ifndef IEC_DEFINES_SVH
`define IEC_DEFINES_SVH
`define IEC_CH_STRIDE    8'h20
`define IEC_OFS_CTRL     8'h00
`define IEC_OFS_MAXV     8'h04
`define IEC_OFS_START    8'h08
`define IEC_OFS_SETV     8'h0C
`define IEC_OFS_COUNT    8'h10
`define IEC_OFS_LATCH    8'h14
`define IEC_OFS_CMD      8'h18
`define IEC_OFS_STAT     8'h1C
`define IEC_OFS_GCTRL    8'h60
`define IEC_OFS_EXPO     8'h64
`define IEC_OFS_TRIG     8'h68
`define IEC_OFS_PERIOD   8'h6C
`define IEC_GCTRL_RUN    0
`define IEC_GCTRL_SLAVE  1
`define IEC_GCTRL_TRIGCH 5:4
`define IEC_CTRL_INTERP  1:0
`define IEC_CTRL_REFMODE 3:2
`define IEC_CMD_SETSTART 0
`define IEC_CMD_SETVAL   1
`define IEC_CMD_REARM    2
`define IEC_MAXV_RESET   32'hFFFFFFFF
`define IEC_START_RESET  32'h00000000
`define IEC_EXPO_RESET   32'h00001000
`define IEC_PERIOD_RESET 32'h00002000
`endif

// ==== iec_pkg.sv ====
// Purpose: Types for the incremental encoder counter
// Assumes: Included by all design files
// Notes:   Encodings are binary and fixed
package iec_pkg;
	typedef enum logic [1:0] {
		IEC_X1 = 2'h0,
		IEC_X2 = 2'h1,
		IEC_X4 = 2'h2
	} iec_interp_t;
	typedef enum logic [1:0] {
		IEC_REF_NONE  = 2'h0,
		IEC_REF_FIRST = 2'h1,
		IEC_REF_EVERY = 2'h2
	} iec_refmode_t;
	typedef enum logic [1:0] {
		IEC_MS_IDLE = 2'h0,
		IEC_MS_EXPO = 2'h1,
		IEC_MS_WAIT = 2'h2
	} iec_mstate_t;
endpackage

// ==== iec_sync3.sv ====
// Purpose: Three-stage pin synchroniser with agreement filter
// Assumes: Asynchronous input pins
// Notes:   Output changes once stages two and three agree
`timescale 1ns/1ps
module iec_sync3 #(
	parameter int W = 1
) (
	input  wire logic         i_mclk,
	input  wire logic         i_resetn,
	input  wire logic [W-1:0] i_pin,
	output logic      [W-1:0] o_level
);
	import iec_pkg::*;
	logic [W-1:0] s1_reg;
	logic [W-1:0] s2_reg;
	logic [W-1:0] s3_reg;
	// Chain of three flip-flops, first read only by the second
	always_ff @(posedge i_mclk or negedge i_resetn) begin
		if (!i_resetn) begin
			s1_reg <= '0;
			s2_reg <= '0;
			s3_reg <= '0;
		end else begin
			s1_reg <= i_pin;
			s2_reg <= s1_reg;
			s3_reg <= s2_reg;
		end
	end
	// Take a new level only when the last two stages agree
	genvar g;
	generate
		for (g = 0; g < W; g++) begin : g_bit
			always_ff @(posedge i_mclk or negedge i_resetn) begin
				if (!i_resetn)
					o_level[g] <= 1'b0;
				else if (s2_reg[g] == s3_reg[g])
					o_level[g] <= s3_reg[g];
			end
		end
	endgenerate
endmodule

// ==== iec_channel.sv ====
// Purpose: One quadrature counter channel
// Assumes: Synchronised A, B and reference levels
// Notes:   Count wraps above the maximum value to zero
`timescale 1ns/1ps
`include "iec_defines.svh"
module iec_channel (
	input  wire logic                 i_mclk,
	input  wire logic                 i_resetn,
	input  wire logic                 i_a,
	input  wire logic                 i_b,
	input  wire logic                 i_ref,
	input  wire iec_pkg::iec_interp_t  i_interp,
	input  wire iec_pkg::iec_refmode_t i_refmode,
	input  wire logic [31:0]          i_maxv,
	input  wire logic [31:0]          i_start,
	input  wire logic                 i_load_start,
	input  wire logic                 i_load_val,
	input  wire logic [31:0]          i_val,
	input  wire logic                 i_rearm,
	output logic      [31:0]          o_count,
	output logic                      o_ref_seen,
	output logic                      o_illegal
);
	import iec_pkg::*;
	logic [1:0]  ab_prev_reg;
	logic        ref_prev_reg;
	logic        init_reg;
	logic [1:0]  ab;
	logic        step;
	logic        up;
	logic        illegal;
	logic        ref_rise;
	logic        ref_load;
	logic [31:0] count_next;
	assign ab = {i_a, i_b};
	assign ref_rise = i_ref & ~ref_prev_reg;
	// Decode a step and direction from the track transition
	always_comb begin
		step = 1'b0;
		up = 1'b0;
		illegal = 1'b0;
		case ({ab_prev_reg, ab})
			4'h2, 4'hB, 4'hD, 4'h4: begin
				up = 1'b1;
				step = 1'b1;
			end
			4'h1, 4'h7, 4'hE, 4'h8: begin
				step = 1'b1;
			end
			4'h3, 4'hC, 4'h6, 4'h9: illegal = 1'b1;
			default: step = 1'b0;
		endcase
		// Fewer counted edges at lower interpolation
		case (i_interp)
			IEC_X1: if (ab_prev_reg[0] == ab[0]
				|| !ab_prev_reg[1] || !ab[1]) step = 1'b0;
			IEC_X2: if (ab_prev_reg[1] == ab[1]) step = 1'b0;
			default: ;
		endcase
	end
	assign ref_load = ref_rise && ((i_refmode == IEC_REF_EVERY)
		|| (i_refmode == IEC_REF_FIRST && !o_ref_seen));
	// Next count value with wrap past the maximum
	always_comb begin
		count_next = o_count;
		if (step) begin
			if (up)
				count_next = (o_count >= i_maxv) ? 32'h0
					: o_count + 32'h1;
			else
				count_next = (o_count == 32'h0) ? i_maxv
					: o_count - 32'h1;
		end
	end
	// Counter register with loads taking priority over steps
	always_ff @(posedge i_mclk or negedge i_resetn) begin
		if (!i_resetn) begin
			o_count <= `IEC_START_RESET;
			init_reg <= 1'b1;
		end else begin
			init_reg <= 1'b0;
			if (init_reg || i_load_start || ref_load)
				o_count <= i_start;
			else if (i_load_val)
				o_count <= i_val;
			else
				o_count <= count_next;
		end
	end
	// Track history and reference record
	always_ff @(posedge i_mclk or negedge i_resetn) begin
		if (!i_resetn) begin
			ab_prev_reg <= 2'h0;
			ref_prev_reg <= 1'b0;
			o_ref_seen <= 1'b0;
			o_illegal <= 1'b0;
		end else begin
			ab_prev_reg <= ab;
			ref_prev_reg <= i_ref;
			o_illegal <= illegal;
			if (ref_rise && i_refmode == IEC_REF_FIRST)
				o_ref_seen <= 1'b1;
			else if (i_rearm)
				o_ref_seen <= 1'b0;
		end
	end
	chk_first_mark_once: assert property (@(posedge i_mclk)
		disable iff (!i_resetn)
		(ref_rise && i_refmode == IEC_REF_FIRST && o_ref_seen
		&& !i_load_start && !i_load_val && !init_reg && !step)
		|=> o_count == $past(o_count))
		else $error("later mark reloaded counter");
	chk_every_mark: assert property (@(posedge i_mclk)
		disable iff (!i_resetn)
		(ref_rise && i_refmode == IEC_REF_EVERY)
		|=> o_count == $past(i_start))
		else $error("mark did not load start");
	chk_wrap_zero: assert property (@(posedge i_mclk)
		disable iff (!i_resetn)
		(step && up && o_count == i_maxv && !ref_load && !init_reg
		&& !i_load_start && !i_load_val) |=> o_count == 32'h0)
		else $error("count did not wrap");
	chk_illegal_hold: assert property (@(posedge i_mclk)
		disable iff (!i_resetn)
		(illegal && !ref_load && !init_reg && !i_load_start
		&& !i_load_val) |=> o_count == $past(o_count))
		else $error("illegal transition counted");
	chk_rearm_clear: assert property (@(posedge i_mclk)
		disable iff (!i_resetn)
		(i_rearm && !(ref_rise && i_refmode == IEC_REF_FIRST))
		|=> !o_ref_seen)
		else $error("rearm did not clear");
	chk_set_value: assert property (@(posedge i_mclk)
		disable iff (!i_resetn)
		(i_load_val && !i_load_start && !ref_load && !init_reg)
		|=> o_count == $past(i_val))
		else $error("direct write lost");
endmodule

// ==== iec_top.sv ====
// Purpose: Three-channel encoder counter with exposure-centred latch
// Assumes: Avalon-MM slave, 50 MHz i_mclk, async active-low reset
// Notes:   Waitrequest is low on the access after one wait state
//
// The Avalon-MM slave port and the address map were left to the implementer.
`timescale 1ns/1ps
`include "iec_defines.svh"
module iec_top #(
	parameter int NCH = 3
) (
	input  wire logic             i_mclk,
	input  wire logic             i_resetn,
	input  wire logic [7:0]       i_avs_address,
	input  wire logic             i_avs_read,
	input  wire logic             i_avs_write,
	input  wire logic [31:0]      i_avs_writedata,
	input  wire logic [3:0]       i_avs_byteenable,
	output logic      [31:0]      o_avs_readdata,
	output logic                  o_avs_waitrequest,
	input  wire logic [NCH-1:0]   i_track_a,
	input  wire logic [NCH-1:0]   i_track_b,
	input  wire logic [NCH-1:0]   i_ref_mark,
	input  wire logic             i_external_sync_trigger_input,
	output logic                  o_meas_start,
	output logic                  o_meas_valid,
	output logic [NCH*32-1:0]     o_meas_count,
	output logic                  o_enc_trigger
);
	import iec_pkg::*;
	logic [NCH-1:0]    a_s;
	logic [NCH-1:0]    b_s;
	logic [NCH-1:0]    r_s;
	logic              sync_s;
	logic              sync_prev_reg;
	logic              ack_reg;
	logic [31:0]       rdata_next;
	logic [3:0]        ctrl_reg [NCH];
	logic [31:0]       maxv_reg [NCH];
	logic [31:0]       start_reg [NCH];
	logic [31:0]       setv_reg [NCH];
	logic [NCH-1:0]    ld_start;
	logic [NCH-1:0]    ld_val;
	logic [NCH-1:0]    rearm;
	logic [31:0]       count [NCH];
	logic [NCH-1:0]    ref_seen;
	logic [NCH-1:0]    illegal;
	logic [NCH-1:0]    illegal_reg;
	logic              slave_reg;
	logic              run_reg;
	logic [1:0]        trig_ch_reg;
	logic [31:0]       trig_thr_reg;
	logic [31:0]       expo_reg;
	logic [31:0]       period_reg;
	logic [31:0]       tmr_reg;
	logic [31:0]       half;
	logic              cyc_go;
	logic              wr;
	logic              rd;
	iec_mstate_t       ms_reg;

	// Pin synchronisers for all tracks and the sync input
	iec_sync3 #(.W(3*NCH+1)) u_sync (
		.i_mclk   (i_mclk),
		.i_resetn (i_resetn),
		.i_pin    ({i_external_sync_trigger_input, i_ref_mark,
			i_track_b, i_track_a}),
		.o_level  ({sync_s, r_s, b_s, a_s})
	);

	// Bus decode; writes land on the accept edge, reads a cycle early
	assign wr = i_avs_write && ack_reg;
	assign rd = i_avs_read && !ack_reg;
	assign o_avs_waitrequest = (i_avs_read || i_avs_write) && !ack_reg;
	always_ff @(posedge i_mclk or negedge i_resetn) begin
		if (!i_resetn)
			ack_reg <= 1'b0;
		else
			ack_reg <= (i_avs_read || i_avs_write) && !ack_reg;
	end

	// Per-channel registers and counters
	genvar c;
	generate
		for (c = 0; c < NCH; c++) begin : g_ch
			localparam logic [7:0] BASE = 8'(c) * `IEC_CH_STRIDE;
			logic sel;
			assign sel = wr && i_avs_address >= BASE
				&& i_avs_address < BASE + `IEC_CH_STRIDE;
			// Configuration registers, one set per channel
			always_ff @(posedge i_mclk or negedge i_resetn) begin
				if (!i_resetn) begin
					ctrl_reg[c] <= 4'h0;
					maxv_reg[c] <= `IEC_MAXV_RESET;
					start_reg[c] <= `IEC_START_RESET;
					setv_reg[c] <= `IEC_START_RESET;
				end else if (sel) begin
					case (i_avs_address - BASE)
						`IEC_OFS_CTRL: ctrl_reg[c] <= i_avs_writedata[3:0];
						`IEC_OFS_MAXV: maxv_reg[c] <= i_avs_writedata;
						`IEC_OFS_START: start_reg[c] <= i_avs_writedata;
						`IEC_OFS_SETV: setv_reg[c] <= i_avs_writedata;
						default: ;
					endcase
				end
			end
			// Command strobes, one cycle each
			always_ff @(posedge i_mclk or negedge i_resetn) begin
				if (!i_resetn) begin
					ld_start[c] <= 1'b0;
					ld_val[c] <= 1'b0;
					rearm[c] <= 1'b0;
				end else begin
					ld_start[c] <= sel && i_avs_address - BASE ==
						`IEC_OFS_CMD
						&& i_avs_writedata[`IEC_CMD_SETSTART];
					ld_val[c] <= sel && i_avs_address - BASE ==
						`IEC_OFS_CMD
						&& i_avs_writedata[`IEC_CMD_SETVAL];
					rearm[c] <= sel && i_avs_address - BASE ==
						`IEC_OFS_CMD
						&& i_avs_writedata[`IEC_CMD_REARM];
				end
			end
			// Sticky record of rejected transitions
			always_ff @(posedge i_mclk or negedge i_resetn) begin
				if (!i_resetn)
					illegal_reg[c] <= 1'b0;
				else if (illegal[c])
					illegal_reg[c] <= 1'b1;
				else if (sel && i_avs_address - BASE == `IEC_OFS_STAT)
					illegal_reg[c] <= 1'b0;
			end
			iec_channel u_ch (
				.i_mclk       (i_mclk),
				.i_resetn     (i_resetn),
				.i_a          (a_s[c]),
				.i_b          (b_s[c]),
				.i_ref        (r_s[c]),
				.i_interp     (iec_interp_t'(ctrl_reg[c][`IEC_CTRL_INTERP])),
				.i_refmode    (iec_refmode_t'(ctrl_reg[c][`IEC_CTRL_REFMODE])),
				.i_maxv       (maxv_reg[c]),
				.i_start      (start_reg[c]),
				.i_load_start (ld_start[c]),
				.i_load_val   (ld_val[c]),
				.i_val        (setv_reg[c]),
				.i_rearm      (rearm[c]),
				.o_count      (count[c]),
				.o_ref_seen   (ref_seen[c]),
				.o_illegal    (illegal[c])
			);
			// Latch at mid exposure onto the measurement bus
			always_ff @(posedge i_mclk or negedge i_resetn) begin
				if (!i_resetn)
					o_meas_count[c*32 +: 32] <= 32'h0;
				else if (ms_reg == IEC_MS_EXPO && tmr_reg == half)
					o_meas_count[c*32 +: 32] <= count[c];
			end
		end
	endgenerate

	// Global control: slave mode, run, trigger channel, timings
	always_ff @(posedge i_mclk or negedge i_resetn) begin
		if (!i_resetn) begin
			slave_reg <= 1'b0;
			run_reg <= 1'b0;
			trig_ch_reg <= 2'h0;
			expo_reg <= `IEC_EXPO_RESET;
			period_reg <= `IEC_PERIOD_RESET;
			trig_thr_reg <= 32'h0;
		end else if (wr) begin
			case (i_avs_address)
				`IEC_OFS_GCTRL: begin
					run_reg <= i_avs_writedata[`IEC_GCTRL_RUN];
					slave_reg <= i_avs_writedata[`IEC_GCTRL_SLAVE];
					trig_ch_reg <= i_avs_writedata[`IEC_GCTRL_TRIGCH];
				end
				`IEC_OFS_EXPO: begin
					expo_reg <= i_avs_writedata;
					period_reg <= (i_avs_writedata > period_reg)
						? i_avs_writedata : period_reg;
				end
				`IEC_OFS_TRIG: trig_thr_reg <= i_avs_writedata;
				`IEC_OFS_PERIOD: period_reg <= i_avs_writedata;
				default: ;
			endcase
		end
	end

	// Encoder trigger: selected channel at or above threshold
	always_ff @(posedge i_mclk or negedge i_resetn) begin
		if (!i_resetn)
			o_enc_trigger <= 1'b0;
		else
			o_enc_trigger <= trig_ch_reg < 2'(NCH)
				&& count[trig_ch_reg] >= trig_thr_reg;
	end

	// Cycle start: master timer or synchronised sync edge
	assign half = expo_reg >> 1;
	assign cyc_go = run_reg && (slave_reg ? (sync_s && !sync_prev_reg)
		: (ms_reg == IEC_MS_IDLE));
	always_ff @(posedge i_mclk or negedge i_resetn) begin
		if (!i_resetn)
			sync_prev_reg <= 1'b0;
		else
			sync_prev_reg <= sync_s;
	end

	// Measurement cycle: exposure, then in master mode wait out the period
	always_ff @(posedge i_mclk or negedge i_resetn) begin
		if (!i_resetn) begin
			ms_reg <= IEC_MS_IDLE;
			tmr_reg <= 32'h0;
			o_meas_start <= 1'b0;
			o_meas_valid <= 1'b0;
		end else begin
			o_meas_start <= 1'b0;
			o_meas_valid <= 1'b0;
			tmr_reg <= tmr_reg + 32'h1;
			case (ms_reg)
				IEC_MS_IDLE: if (cyc_go) begin
					ms_reg <= IEC_MS_EXPO;
					tmr_reg <= 32'h0;
					o_meas_start <= 1'b1;
				end
				IEC_MS_EXPO: if (tmr_reg >= expo_reg) begin
					ms_reg <= IEC_MS_WAIT;
					o_meas_valid <= 1'b1;
				end
				IEC_MS_WAIT: if (slave_reg || tmr_reg >= period_reg)
					ms_reg <= IEC_MS_IDLE;
				default: ms_reg <= IEC_MS_IDLE;
			endcase
		end
	end

	// Read mux
	always_comb begin
		rdata_next = 32'h0;
		for (int i = 0; i < NCH; i++) begin
			if (i_avs_address[7:5] == 3'(i)) begin
				case (i_avs_address[4:0])
					5'(`IEC_OFS_CTRL): rdata_next = {28'h0, ctrl_reg[i]};
					5'(`IEC_OFS_MAXV): rdata_next = maxv_reg[i];
					5'(`IEC_OFS_START): rdata_next = start_reg[i];
					5'(`IEC_OFS_SETV): rdata_next = setv_reg[i];
					5'(`IEC_OFS_COUNT): rdata_next = count[i];
					5'(`IEC_OFS_LATCH): rdata_next = o_meas_count[i*32 +: 32];
					5'(`IEC_OFS_STAT): rdata_next = {30'h0, illegal_reg[i],
						ref_seen[i]};
					default: rdata_next = 32'h0;
				endcase
			end
		end
		case (i_avs_address)
			`IEC_OFS_GCTRL: rdata_next = {26'h0, trig_ch_reg, 2'h0,
				slave_reg, run_reg};
			`IEC_OFS_EXPO: rdata_next = expo_reg;
			`IEC_OFS_TRIG: rdata_next = trig_thr_reg;
			`IEC_OFS_PERIOD: rdata_next = period_reg;
			default: ;
		endcase
	end
	always_ff @(posedge i_mclk or negedge i_resetn) begin
		if (!i_resetn)
			o_avs_readdata <= 32'h0;
		else if (rd)
			o_avs_readdata <= rdata_next;
	end

	chk_mid_latch: assert property (@(posedge i_mclk)
		disable iff (!i_resetn)
		(ms_reg == IEC_MS_EXPO && tmr_reg == half)
		|=> o_meas_count[31:0] == $past(count[0]))
		else $error("count not latched mid exposure");
	chk_slave_start: assert property (@(posedge i_mclk)
		disable iff (!i_resetn)
		(o_meas_start && slave_reg && $past(slave_reg))
		|-> $past(sync_s && !sync_prev_reg))
		else $error("slave cycle without sync edge");
	chk_bus_wait: assert property (@(posedge i_mclk)
		disable iff (!i_resetn)
		(i_avs_read && o_avs_waitrequest) |=> !o_avs_waitrequest)
		else $error("waitrequest held too long");

	// Exposure end raises the valid pulse
	chk_valid_end: assert property (@(posedge i_mclk)
		disable iff (!i_resetn)
		(ms_reg == IEC_MS_EXPO && tmr_reg >= expo_reg) |=> o_meas_valid)
		else $error("no valid pulse at exposure end");

	// Attached counts move only inside the exposure
	chk_latch_hold: assert property (@(posedge i_mclk)
		disable iff (!i_resetn)
		(ms_reg != IEC_MS_EXPO) |=> $stable(o_meas_count))
		else $error("attached count moved outside exposure");

	// Trigger level follows the channel zero threshold
	chk_trig_level: assert property (@(posedge i_mclk)
		disable iff (!i_resetn)
		(trig_ch_reg == 2'h0 && count[0] >= trig_thr_reg)
		|=> o_enc_trigger)
		else $error("encoder trigger missing");

	// A cycle starts only from the idle state
	chk_start_idle: assert property (@(posedge i_mclk)
		disable iff (!i_resetn)
		o_meas_start |-> $past(ms_reg) == IEC_MS_IDLE)
		else $error("cycle started while busy");

	// A rejected transition sets the sticky record
	chk_sticky_set: assert property (@(posedge i_mclk)
		disable iff (!i_resetn)
		illegal[0] |=> illegal_reg[0])
		else $error("rejected transition not recorded");

	// A maximum written on the accept edge lands
	chk_write_lands: assert property (@(posedge i_mclk)
		disable iff (!i_resetn)
		(wr && i_avs_address == `IEC_OFS_MAXV)
		|=> maxv_reg[0] == $past(i_avs_writedata))
		else $error("maximum value write lost");

	// A re-arm command becomes a strobe
	chk_rearm_strobe: assert property (@(posedge i_mclk)
		disable iff (!i_resetn)
		(wr && i_avs_address == `IEC_OFS_CMD
		&& i_avs_writedata[`IEC_CMD_REARM]) |=> rearm[0])
		else $error("re-arm strobe missing");
endmodule

// ==== iec_enc_model.sv ====
// Purpose: Quadrature encoder with reference track, three channels
// Assumes: Edges spaced wider than the pin synchroniser delay
// Notes:   Counting up walks {A,B} through 00, 10, 11, 01; A leads
`timescale 1ns/1ps
module iec_enc_model #(
	parameter int NCH = 3
) (
	input  wire logic           i_mclk,
	output logic      [NCH-1:0] o_a,
	output logic      [NCH-1:0] o_b,
	output logic      [NCH-1:0] o_ref
);
	localparam logic [1:0] GRAY [4] = '{2'h0, 2'h2, 2'h3, 2'h1};
	int ph [NCH];

	// Tracks idle low at time zero
	initial begin
		o_a = '0;
		o_b = '0;
		o_ref = '0;
		foreach (ph[i]) ph[i] = 0;
	end

	// One gray step; direction sits in the A/B phase order
	task automatic step(input int ch, input bit up);
		ph[ch] = up ? (ph[ch] + 1) % 4 : (ph[ch] + 3) % 4;
		@(posedge i_mclk);
		o_a[ch] <= GRAY[ph[ch]][1];
		o_b[ch] <= GRAY[ph[ch]][0];
		repeat (8) @(posedge i_mclk);
	endtask

	// Both tracks flip at once, a broken sequence
	task automatic jump(input int ch);
		ph[ch] = (ph[ch] + 2) % 4;
		@(posedge i_mclk);
		o_a[ch] <= GRAY[ph[ch]][1];
		o_b[ch] <= GRAY[ph[ch]][0];
		repeat (8) @(posedge i_mclk);
	endtask

	// Reference mark pulse, eight cycles wide
	task automatic mark(input int ch);
		@(posedge i_mclk);
		o_ref[ch] <= 1'b1;
		repeat (8) @(posedge i_mclk);
		o_ref[ch] <= 1'b0;
		repeat (8) @(posedge i_mclk);
	endtask
endmodule

// ==== iec_top_tb.sv ====
// Purpose: Self-checking bench for the encoder counter
// Assumes: One wait state per bus access, commands land in two cycles
// Notes:   Byte enables full on every access; full-word accesses only
`timescale 1ns/1ps
`include "iec_defines.svh"
module iec_top_tb;
	import iec_pkg::*;
	logic        mclk;
	logic        resetn;
	logic [7:0]  avs_address;
	logic        avs_read;
	logic        avs_write;
	logic [31:0] avs_writedata;
	logic [3:0]  avs_byteenable;
	logic [31:0] avs_readdata;
	logic        avs_waitrequest;
	logic [2:0]  trk_a;
	logic [2:0]  trk_b;
	logic [2:0]  trk_ref;
	logic        sync_in;
	logic        meas_start;
	logic        meas_valid;
	logic [95:0] meas_count;
	logic        enc_trigger;
	int          n_fail;
	int          n_compared;

	iec_top iec_top_i (
		.i_mclk(mclk), .i_resetn(resetn), .i_avs_address(avs_address),
		.i_avs_read(avs_read), .i_avs_write(avs_write),
		.i_avs_writedata(avs_writedata), .i_avs_byteenable(avs_byteenable),
		.o_avs_readdata(avs_readdata), .o_avs_waitrequest(avs_waitrequest),
		.i_track_a(trk_a), .i_track_b(trk_b), .i_ref_mark(trk_ref),
		.i_external_sync_trigger_input(sync_in), .o_meas_start(meas_start),
		.o_meas_valid(meas_valid), .o_meas_count(meas_count),
		.o_enc_trigger(enc_trigger));
	iec_enc_model iec_enc_model_i (
		.i_mclk(mclk), .o_a(trk_a), .o_b(trk_b), .o_ref(trk_ref));

	// Free-running 50 MHz clock
	always #10 mclk = ~mclk;

	task automatic final_report();
		$display("compared %0d, mismatched %0d", n_compared, n_fail);
		if (n_fail == 0 && n_compared > 0)
			$display("== PASSED ==");
		else
			$display("== FAILED ==");
		$finish;
	endtask

	task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
		n_compared++;
		if (seen !== exp) begin
			n_fail++;
			$display("BAD t=%0t seen=%h exp=%h", $time, seen, exp);
		end
	endtask

	task automatic expire();
		n_fail++;
		$display("BAD t=%0t seen=%h exp=%h timeout", $time, 1'b0, 1'b1);
		final_report();
	endtask

	// Bus cycle held until waitrequest is sampled low
	task automatic bus(input bit w, input logic [7:0] a,
		input logic [31:0] d, output logic [31:0] q);
		int n;
		@(posedge mclk);
		avs_address <= a;
		avs_writedata <= d;
		avs_byteenable <= 4'hF;
		avs_read <= !w;
		avs_write <= w;
		n = 0;
		do begin
			@(posedge mclk);
			n++;
		end while (avs_waitrequest !== 1'b0 && n < 64);
		q = avs_readdata;
		avs_read <= 1'b0;
		avs_write <= 1'b0;
		if (n >= 64) expire();
	endtask

	task automatic wr(input logic [7:0] a, input logic [31:0] d);
		logic [31:0] q;
		bus(1'b1, a, d, q);
	endtask

	task automatic rdc(input logic [7:0] a, input logic [31:0] exp);
		logic [31:0] q;
		bus(1'b0, a, 32'h0, q);
		chk(q, exp);
	endtask

	function automatic logic [7:0] ra(input int c, input logic [7:0] o);
		return 8'(c) * `IEC_CH_STRIDE + o;
	endfunction

	// Command write, then four cycles to cover the two-cycle landing delay
	task automatic cmd(input int c, input logic [31:0] b);
		wr(ra(c, `IEC_OFS_CMD), b);
		repeat (4) @(posedge mclk);
	endtask

	task automatic setup(input int c, input iec_interp_t ip,
		input iec_refmode_t rm, input logic [31:0] mx, input logic [31:0] st);
		wr(ra(c, `IEC_OFS_CTRL), {28'h0, rm, ip});
		wr(ra(c, `IEC_OFS_MAXV), mx);
		wr(ra(c, `IEC_OFS_START), st);
		cmd(c, 32'h1);
	endtask

	// Bounded wait for a measurement pulse, start or end
	task automatic wait_pulse(input bit v, input int lim);
		int n;
		n = 0;
		do begin
			@(posedge mclk);
			n++;
		end while ((v ? meas_valid : meas_start) !== 1'b1 && n < lim);
		if (n >= lim) expire();
	endtask

	task automatic t_reset();
		rdc(ra(0, `IEC_OFS_MAXV), `IEC_MAXV_RESET);
		rdc(ra(2, `IEC_OFS_START), 32'h0);
		wr(ra(1, `IEC_OFS_COUNT), 32'h55);
		rdc(ra(1, `IEC_OFS_COUNT), 32'h0);
		wr(8'h7C, 32'h1234);
		rdc(8'h7C, 32'h0);
		$display("test reset done");
	endtask

	// Each channel its own resolution, one period up then down
	task automatic t_interp();
		for (int c = 0; c < 3; c++)
			setup(c, iec_interp_t'(c), IEC_REF_NONE, 32'hFFFFFFFF,
				32'h100 * (c + 1));
		for (int c = 0; c < 3; c++)
			repeat (4) iec_enc_model_i.step(c, 1'b1);
		for (int c = 0; c < 3; c++)
			rdc(ra(c, `IEC_OFS_COUNT), 32'h100 * (c + 1) + (1 << c));
		for (int c = 0; c < 3; c++)
			repeat (4) iec_enc_model_i.step(c, 1'b0);
		for (int c = 0; c < 3; c++)
			rdc(ra(c, `IEC_OFS_COUNT), 32'h100 * (c + 1));
		$display("test interp done");
	endtask

	task automatic t_wrap();
		setup(0, IEC_X4, IEC_REF_NONE, 32'h5, 32'h3);
		repeat (4) iec_enc_model_i.step(0, 1'b1);
		rdc(ra(0, `IEC_OFS_COUNT), 32'h1);
		repeat (2) iec_enc_model_i.step(0, 1'b0);
		rdc(ra(0, `IEC_OFS_COUNT), 32'h5);
		$display("test wrap done");
	endtask

	// Mark modes: none, first with re-arm, every
	task automatic t_ref();
		setup(1, IEC_X4, IEC_REF_NONE, 32'hFFFFFFFF, 32'h40);
		repeat (2) iec_enc_model_i.step(1, 1'b1);
		iec_enc_model_i.mark(1);
		rdc(ra(1, `IEC_OFS_COUNT), 32'h42);
		wr(ra(1, `IEC_OFS_CTRL), {28'h0, IEC_REF_FIRST, IEC_X4});
		cmd(1, 32'h4);
		iec_enc_model_i.mark(1);
		rdc(ra(1, `IEC_OFS_COUNT), 32'h40);
		repeat (2) iec_enc_model_i.step(1, 1'b1);
		iec_enc_model_i.mark(1);
		rdc(ra(1, `IEC_OFS_COUNT), 32'h42);
		cmd(1, 32'h4);
		iec_enc_model_i.mark(1);
		rdc(ra(1, `IEC_OFS_COUNT), 32'h40);
		wr(ra(1, `IEC_OFS_CTRL), {28'h0, IEC_REF_EVERY, IEC_X4});
		repeat (3) iec_enc_model_i.step(1, 1'b1);
		iec_enc_model_i.mark(1);
		rdc(ra(1, `IEC_OFS_COUNT), 32'h40);
		repeat (2) iec_enc_model_i.step(1, 1'b0);
		iec_enc_model_i.mark(1);
		rdc(ra(1, `IEC_OFS_COUNT), 32'h40);
		iec_enc_model_i.mark(0);
		iec_enc_model_i.mark(2);
		rdc(ra(0, `IEC_OFS_COUNT), 32'h5);
		rdc(ra(2, `IEC_OFS_COUNT), 32'h300);
		$display("test ref done");
	endtask

	task automatic t_setval();
		logic [31:0] q;
		wr(ra(2, `IEC_OFS_SETV), 32'hABCD);
		cmd(2, 32'h2);
		rdc(ra(2, `IEC_OFS_COUNT), 32'hABCD);
		cmd(2, 32'h1);
		rdc(ra(2, `IEC_OFS_COUNT), 32'h300);
		setup(0, IEC_X4, IEC_REF_NONE, 32'hFFFFFFFF, 32'h10);
		wr(ra(0, `IEC_OFS_STAT), 32'h0);
		iec_enc_model_i.jump(0);
		rdc(ra(0, `IEC_OFS_COUNT), 32'h10);
		bus(1'b0, ra(0, `IEC_OFS_STAT), 32'h0, q);
		chk({31'h0, q[1]}, 32'h1);
		$display("test setval done");
	endtask

	// Step before and after mid exposure; only the first is attached
	task automatic t_latch();
		logic [31:0] c0;
		logic [31:0] c1;
		int n;
		wr(`IEC_OFS_EXPO, 32'h40);
		wr(8'h6C, 32'h80);
		bus(1'b0, ra(0, `IEC_OFS_COUNT), 32'h0, c0);
		bus(1'b0, ra(1, `IEC_OFS_COUNT), 32'h0, c1);
		wr(`IEC_OFS_TRIG, c0 + 32'h1);
		repeat (2) @(posedge mclk);
		chk(32'(enc_trigger), 32'h0);
		wr(`IEC_OFS_GCTRL, 32'h1);
		wait_pulse(1'b0, 400);
		iec_enc_model_i.step(0, 1'b1);
		repeat (28) @(posedge mclk);
		iec_enc_model_i.step(0, 1'b1);
		wait_pulse(1'b1, 200);
		chk(meas_count[31:0], c0 + 32'h1);
		chk(meas_count[63:32], c1);
		chk(32'(enc_trigger), 32'h1);
		rdc(ra(0, `IEC_OFS_LATCH), c0 + 32'h1);
		wr(`IEC_OFS_GCTRL, 32'h3);
		repeat (300) @(posedge mclk);
		n = 0;
		repeat (300) begin
			@(posedge mclk);
			if (meas_start === 1'b1) n++;
		end
		chk(32'(n), 32'h0);
		@(posedge mclk);
		sync_in <= 1'b1;
		wait_pulse(1'b0, 50);
		repeat (250) @(posedge mclk);
		sync_in <= 1'b0;
		wr(`IEC_OFS_GCTRL, 32'h0);
		$display("test latch done");
	endtask

	// Reset, then the scenarios in turn
	initial begin
		mclk = 1'b0;
		resetn = 1'b0;
		avs_address = 8'h0;
		avs_read = 1'b0;
		avs_write = 1'b0;
		avs_writedata = 32'h0;
		avs_byteenable = 4'h0;
		sync_in = 1'b0;
		n_fail = 0;
		n_compared = 0;
		repeat (20) @(posedge mclk);
		resetn <= 1'b1;
		repeat (2) @(posedge mclk);
		t_reset();
		t_interp();
		t_wrap();
		t_ref();
		t_setval();
		t_latch();
		final_report();
	end
endmodule
